// *** src/dmd_datapath.sv ***
// multiply / multiply-subtract datapath with x/y prefetch and write-back
// Functional notes
// (RULE_01) multiply-subtract takes the two operand registers' product from the chosen accumulator.
// (RULE_02) x prefetch is optional and, when off, no x read happens and its modifier and target are ignored.
// (RULE_03) y prefetch is optional and, when off, no y read happens and its modifier and target are ignored.
// (RULE_04) after a prefetch its pointer steps by -6, -4, -2, 0, 2, 4 or 6.
// (RULE_05) each prefetched word lands in a named working register for later multiplies.
// (RULE_06) with write-back on, the accumulator not targeted is stored to the given destination.
// (RULE_07) x prefetch uses only the x memory port and y prefetch only the y memory port.
// (RULE_08) signed-by-signed multiply gives a signed 32-bit product.
// (RULE_09) signed-by-unsigned multiply gives a signed product and takes an immediate second operand.
// (RULE_10) unsigned-by-signed multiply gives a signed product.
// (RULE_11) unsigned-by-unsigned multiply gives an unsigned product and takes an immediate second operand.
// (RULE_12) no-operation changes no register, accumulator or memory.
// (RULE_13) integer multiply operands are 16 bits and the product goes to a register pair.
// (RULE_14) prefetches, post-modify and write-back finish within the same instruction.
`include "dmd_map.svh"
module dmd_datapath
  import dmd_pkg::*;
#(
  parameter int W      = `DMD_WORD_W,
  parameter int ACC_W  = `DMD_ACC_W,
  parameter int NREG   = `DMD_REG_COUNT,
  parameter int IDX_W  = `DMD_REG_IDX_W
) (
  // clock and reset
  input  wire logic             core_clk_in,
  input  wire logic             reset_n_in,
  // instruction issue
  input  wire logic             issue_in,
  input  wire dmd_op_t          op_in,
  input  wire logic             acc_sel_in,
  input  wire logic [IDX_W-1:0] src_a_in,
  input  wire logic [IDX_W-1:0] src_b_in,
  input  wire logic             use_imm_in,
  input  wire logic [W-1:0]     imm_in,
  input  wire logic [IDX_W-1:0] dst_in,
  input  wire logic             x_en_in,
  input  wire logic [2:0]       x_incr_in,
  input  wire logic [IDX_W-1:0] x_ptr_reg_in,
  input  wire logic [IDX_W-1:0] x_dst_in,
  input  wire logic             y_en_in,
  input  wire logic [2:0]       y_incr_in,
  input  wire logic [IDX_W-1:0] y_ptr_reg_in,
  input  wire logic [IDX_W-1:0] y_dst_in,
  input  wire logic             wb_en_in,
  input  wire logic [W-1:0]     accum_writeback_target_in,
  // x data memory
  output logic                  x_rd_out,
  output logic      [W-1:0]     x_addr_out,
  input  wire logic [W-1:0]     x_rdata_in,
  // y data memory
  output logic                  y_rd_out,
  output logic      [W-1:0]     y_addr_out,
  input  wire logic [W-1:0]     y_rdata_in,
  // write-back port
  output logic                  wb_we_out,
  output logic      [W-1:0]     wb_addr_out,
  output logic      [W-1:0]     wb_data_out,
  // status and observation
  output logic                  busy_out,
  output logic                  done_out,
  output logic      [ACC_W-1:0] acc_a_out,
  output logic      [ACC_W-1:0] acc_b_out
);
  typedef struct packed {
    dmd_state_t            st;
    logic [NREG-1:0][W-1:0] regs;
    logic [ACC_W-1:0]      acc_a;
    logic [ACC_W-1:0]      acc_b;
    dmd_op_t               op;
    logic                  acc_sel;
    logic                  x_en;
    logic                  y_en;
    logic [2:0]            x_incr;
    logic [2:0]            y_incr;
    logic [IDX_W-1:0]      x_ptr_reg;
    logic [IDX_W-1:0]      y_ptr_reg;
    logic [IDX_W-1:0]      x_dst;
    logic [IDX_W-1:0]      y_dst;
    logic                  x_rd;
    logic [W-1:0]          x_addr;
    logic                  y_rd;
    logic [W-1:0]          y_addr;
    logic                  wb_we;
    logic [W-1:0]          wb_addr;
    logic [W-1:0]          wb_data;
    logic                  busy;
    logic                  done;
  } dmd_state_reg_t;

  dmd_state_reg_t s_q;
  dmd_state_reg_t s_d;

  logic [W-1:0]   mul_a;
  logic [W-1:0]   mul_b;
  logic           a_sgn;
  logic           b_sgn;
  logic [2*W-1:0] prod;
  logic [W-1:0]   x_ptr_next;
  logic [W-1:0]   y_ptr_next;
  logic [ACC_W-1:0] prod_ext;
  logic [ACC_W-1:0] sel_acc;

  // signedness per multiply kind; msc multiplies signed operands
  function automatic logic [1:0] op_signs(input dmd_op_t op);
    case (op)
      DMD_OP_MULTIPLY_SIGNED_BY_UNSIGNED: op_signs = 2'b10; // RULE_09
      DMD_OP_MULTIPLY_UNSIGNED_BY_SIGNED: op_signs = 2'b01; // RULE_10
      DMD_OP_MULTIPLY_UNSIGNED_BY_UNSIGNED: op_signs = 2'b00; // RULE_11
      default:       op_signs = 2'b11; // RULE_08
    endcase
  endfunction : op_signs

  // immediate only legal for su/uu; other kinds always read the register
  function automatic logic imm_allowed(input dmd_op_t op);
    imm_allowed = (op == DMD_OP_MULTIPLY_SIGNED_BY_UNSIGNED) || (op == DMD_OP_MULTIPLY_UNSIGNED_BY_UNSIGNED);
  endfunction : imm_allowed

  always_comb begin
    mul_a = s_q.regs[src_a_in];
    mul_b = (use_imm_in && imm_allowed(op_in)) ? imm_in : s_q.regs[src_b_in]; // RULE_09 RULE_11
    {a_sgn, b_sgn} = op_signs(op_in);
  end

  dmd_mult #(.W(W)) u_mult (
    .a_in        (mul_a),
    .b_in        (mul_b),
    .a_signed_in (a_sgn),
    .b_signed_in (b_sgn),
    .prod_out    (prod)
  );

  dmd_ptr_mod #(.W(W)) u_xptr (
    .ptr_in  (s_q.regs[s_q.x_ptr_reg]),
    .incr_in (s_q.x_incr),
    .ptr_out (x_ptr_next)
  );

  dmd_ptr_mod #(.W(W)) u_yptr (
    .ptr_in  (s_q.regs[s_q.y_ptr_reg]),
    .incr_in (s_q.y_incr),
    .ptr_out (y_ptr_next)
  );

  always_comb begin
    s_d = s_q;
    s_d.x_rd  = 1'b0;
    s_d.y_rd  = 1'b0;
    s_d.wb_we = 1'b0;
    s_d.done  = 1'b0;
    prod_ext = ACC_W'($signed(prod));
    sel_acc  = acc_sel_in ? s_q.acc_b : s_q.acc_a;
    case (s_q.st)
      DMD_ST_IDLE: begin
        s_d.busy = 1'b0;
        if (issue_in) begin
          case (op_in)
            DMD_OP_MSC: begin
              if (acc_sel_in) s_d.acc_b = sel_acc - prod_ext; // RULE_01
              else            s_d.acc_a = sel_acc - prod_ext; // RULE_01
              // operands captured now, so a prefetch into them is seen next op
              s_d.x_en      = x_en_in; // RULE_02
              s_d.y_en      = y_en_in; // RULE_03
              s_d.x_incr    = x_incr_in;
              s_d.y_incr    = y_incr_in;
              s_d.x_ptr_reg = x_ptr_reg_in;
              s_d.y_ptr_reg = y_ptr_reg_in;
              s_d.x_dst     = x_dst_in;
              s_d.y_dst     = y_dst_in;
              s_d.x_rd      = x_en_in; // RULE_07
              s_d.x_addr    = x_en_in ? s_q.regs[x_ptr_reg_in] : s_q.x_addr; // RULE_07
              s_d.y_rd      = y_en_in; // RULE_07
              s_d.y_addr    = y_en_in ? s_q.regs[y_ptr_reg_in] : s_q.y_addr; // RULE_07
              s_d.wb_we     = wb_en_in; // RULE_06
              s_d.wb_addr   = accum_writeback_target_in;
              s_d.wb_data   = wb_en_in ? (acc_sel_in ? s_q.acc_a[W-1:0] : s_q.acc_b[W-1:0]) : s_q.wb_data; // RULE_06
              s_d.op        = op_in;
              s_d.acc_sel   = acc_sel_in;
              s_d.busy      = 1'b1;
              s_d.st        = DMD_ST_FETCH; // RULE_14
            end
            DMD_OP_MUL_SS, DMD_OP_MULTIPLY_SIGNED_BY_UNSIGNED, DMD_OP_MULTIPLY_UNSIGNED_BY_SIGNED, DMD_OP_MULTIPLY_UNSIGNED_BY_UNSIGNED: begin
              // low word to dst, high word to dst+1 (register pair)
              s_d.regs[dst_in]                  = prod[W-1:0];   // RULE_13
              s_d.regs[IDX_W'(dst_in + 1'b1)]   = prod[2*W-1:W]; // RULE_13
              s_d.done = 1'b1;
            end
            default: begin
              s_d.done = 1'b1; // RULE_12
            end
          endcase
        end
      end
      DMD_ST_FETCH: begin
        // memory returns data in the same cycle as the read strobe
        if (s_q.x_en) begin
          s_d.regs[s_q.x_ptr_reg] = x_ptr_next; // RULE_04
          s_d.regs[s_q.x_dst]     = x_rdata_in; // RULE_05
        end
        if (s_q.y_en) begin
          s_d.regs[s_q.y_ptr_reg] = y_ptr_next; // RULE_04
          s_d.regs[s_q.y_dst]     = y_rdata_in; // RULE_05
        end
        s_d.busy = 1'b0;
        s_d.done = 1'b1; // RULE_14
        s_d.st   = DMD_ST_IDLE;
      end
      default: begin
        s_d.st   = DMD_ST_IDLE;
        s_d.busy = 1'b0;
      end
    endcase
  end

  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in) begin
      s_q       <= '0;
      s_q.st    <= DMD_ST_IDLE;
      s_q.acc_a <= `DMD_RST_ACC;
      s_q.acc_b <= `DMD_RST_ACC;
    end else begin
      s_q <= s_d;
    end
  end

  always_comb begin
    x_rd_out    = s_q.x_rd;
    x_addr_out  = s_q.x_addr;
    y_rd_out    = s_q.y_rd;
    y_addr_out  = s_q.y_addr;
    wb_we_out   = s_q.wb_we;
    wb_addr_out = s_q.wb_addr;
    wb_data_out = s_q.wb_data;
    busy_out    = s_q.busy;
    done_out    = s_q.done;
    acc_a_out   = s_q.acc_a;
    acc_b_out   = s_q.acc_b;
  end
endmodule : dmd_datapath

// *** src/dmd_map.svh ***
// widths, field codes, clock rate and reset values of the multiply datapath
`ifndef DMD_MAP_SVH
`define DMD_MAP_SVH
`define DMD_WORD_W       16
`define DMD_ACC_W        40
`define DMD_REG_COUNT    16
`define DMD_REG_IDX_W    4
`define DMD_INCR_W       3
`define DMD_INCR_NONE    3'h0
`define DMD_INCR_STEP    2
`define DMD_CLK_HZ       20000000
`define DMD_RST_ACC      40'h00_0000_0000
`define DMD_RST_WORD     16'h0000
`endif

// *** src/dmd_pkg.sv ***
// types shared by the multiply datapath files
package dmd_pkg;
  typedef enum logic [2:0] {
    DMD_OP_NOP,
    DMD_OP_MSC,
    DMD_OP_MUL_SS,
    DMD_OP_MULTIPLY_SIGNED_BY_UNSIGNED,
    DMD_OP_MULTIPLY_UNSIGNED_BY_SIGNED,
    DMD_OP_MULTIPLY_UNSIGNED_BY_UNSIGNED
  } dmd_op_t;

  typedef enum logic [1:0] {
    DMD_ST_IDLE,
    DMD_ST_FETCH,
    DMD_ST_DONE
  } dmd_state_t;
endpackage : dmd_pkg

// *** src/dmd_mult.sv ***
// 16x16 multiplier with per-operand signedness, 32-bit product
module dmd_mult #(
  parameter int W = 16
) (
  // operands
  input  wire logic [W-1:0]   a_in,
  input  wire logic [W-1:0]   b_in,
  input  wire logic           a_signed_in,
  input  wire logic           b_signed_in,
  // product
  output logic      [2*W-1:0] prod_out
);
  logic signed [W:0]     a_ext;
  logic signed [W:0]     b_ext;
  logic signed [2*W+1:0] full;

  always_comb begin
    a_ext    = {a_signed_in & a_in[W-1], a_in};
    b_ext    = {b_signed_in & b_in[W-1], b_in};
    full     = a_ext * b_ext;
    prod_out = full[2*W-1:0];
  end
endmodule : dmd_mult

// *** src/dmd_ptr_mod.sv ***
// prefetch pointer post-modify by a signed step of -6..+6
module dmd_ptr_mod #(
  parameter int W = 16
) (
  input  wire logic [W-1:0] ptr_in,
  input  wire logic [2:0]   incr_in,
  output logic      [W-1:0] ptr_out
);
  logic signed [W-1:0] step;

  // code is a signed step count; -4 (3'b100) would be -8 so it saturates to -6
  always_comb begin
    case (incr_in)
      3'h1:    step = W'(2);
      3'h2:    step = W'(4);
      3'h3:    step = W'(6);
      3'h4:    step = -W'(6);
      3'h5:    step = -W'(6);
      3'h6:    step = -W'(4);
      3'h7:    step = -W'(2);
      default: step = '0;
    endcase
    ptr_out = ptr_in + step;
  end
endmodule : dmd_ptr_mod

// *** dv/dmd_dp_sva.sv ***
// port-level assertions for the multiply datapath
module dmd_dp_sva
  import dmd_pkg::*;
(
  // clock, reset and issue
  input wire logic        core_clk_in,
  input wire logic        reset_n_in,
  input wire logic        issue_in,
  input wire dmd_op_t     op_in,
  input wire logic        acc_sel_in,
  input wire logic        use_imm_in,
  input wire logic        x_en_in,
  input wire logic        y_en_in,
  input wire logic        wb_en_in,
  input wire logic [15:0] accum_writeback_target_in,
  // outputs under watch
  input wire logic        x_rd_out,
  input wire logic        y_rd_out,
  input wire logic        wb_we_out,
  input wire logic [15:0] wb_addr_out,
  input wire logic [15:0] wb_data_out,
  input wire logic        busy_out,
  input wire logic        done_out,
  input wire logic [39:0] acc_a_out,
  input wire logic [39:0] acc_b_out
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge core_clk_in);
  endclocking
  default disable iff (!reset_n_in);
  wire logic take = issue_in && !busy_out;
  wire logic msc  = take && op_in == DMD_OP_MSC;

  a_msc_fetch_strobes: assert property (msc |=> busy_out && x_rd_out == $past(x_en_in) && y_rd_out == $past(y_en_in))
    else $error("prefetch strobes differ from enables");
  a_msc_done_late: assert property (msc |=> !done_out ##1 done_out && !busy_out)
    else $error("multiply-subtract completion misplaced");
  a_mul_done_next: assert property (take && op_in != DMD_OP_MSC |=> done_out && !busy_out && !wb_we_out)
    else $error("multiply or nop completion misplaced");
  a_acc_hold_idle: assert property (!msc |=> $stable(acc_a_out) && $stable(acc_b_out))
    else $error("accumulator moved without multiply-subtract");
  a_acc_other_kept: assert property (msc |=> $past(acc_sel_in) ? $stable(acc_a_out) : $stable(acc_b_out))
    else $error("untargeted accumulator changed");
  a_wb_one_pulse: assert property (msc |=> wb_we_out == $past(wb_en_in) ##1 !wb_we_out)
    else $error("write-back strobe wrong");
  a_wb_value_other: assert property (msc && wb_en_in |=> wb_addr_out == $past(accum_writeback_target_in)
    && wb_data_out == ($past(acc_sel_in) ? acc_a_out[15:0] : acc_b_out[15:0]))
    else $error("write-back address or data wrong");
  a_no_stray_read: assert property (!msc |=> !x_rd_out && !y_rd_out && !wb_we_out)
    else $error("memory strobe without multiply-subtract");
  a_busy_one_cycle: assert property (busy_out |=> !busy_out)
    else $error("busy longer than one cycle");

  cover property (msc && x_en_in && y_en_in && wb_en_in);
  cover property (issue_in && busy_out);
  cover property (take && op_in == DMD_OP_MULTIPLY_SIGNED_BY_UNSIGNED && use_imm_in);
endmodule : dmd_dp_sva

bind dmd_datapath dmd_dp_sva u_sva (.*);

// *** dv/dmd_mem_model.sv ***
// one data memory port answering prefetch reads
module dmd_mem_model (
  // clock and request
  input  wire logic        core_clk_in,
  input  wire logic        rd_in,
  input  wire logic [15:0] addr_in,
  // answer
  output logic      [15:0] rdata_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] mem [64];
  logic [15:0] last_q = 16'h0000;
  always @(posedge core_clk_in) begin
    if (rd_in) begin
      last_q <= rdata_out;
    end
  end
  // idle bus shows the inverse so a late sample cannot pass by luck
  assign rdata_out = rd_in ? mem[addr_in[6:1]] : ~last_q;
endmodule : dmd_mem_model

// *** dv/testbench.sv ***
// self-checking bench for the multiply datapath
module testbench
  import dmd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {dmd_op_t op; logic [3:0] a; logic [3:0] b; logic imm;} dmd_row_t;
  logic        core_clk_in = 1'b0, reset_n_in = 1'b0, issue_in = 1'b0, acc_sel_in, use_imm_in, x_en_in, y_en_in;
  logic        wb_en_in, x_rd_out, y_rd_out, wb_we_out, busy_out, done_out;
  dmd_op_t     op_in = DMD_OP_NOP;
  logic [3:0]  src_a_in, src_b_in, dst_in = 4'h8, x_ptr_reg_in = 4'he, y_ptr_reg_in = 4'hf, x_dst_in, y_dst_in;
  logic [2:0]  x_incr_in = 3'h1, y_incr_in = 3'h1;
  logic [15:0] imm_in = 16'hfffe, accum_writeback_target_in = 16'h0abc, x_rdata_in, y_rdata_in, rf [16];
  logic [15:0] x_addr_out, y_addr_out, wb_addr_out, wb_data_out;
  logic [39:0] acc_a_out, acc_b_out, ea, eb;
  int          err_count = 0, samples_checked = 0, cyc = 0;
  int          steps [8] = '{0, 2, 4, 6, -6, -6, -4, -2};
  dmd_row_t    rows [9] = '{'{DMD_OP_MUL_SS, 4'h1, 4'h4, 1'b0}, '{DMD_OP_MULTIPLY_SIGNED_BY_UNSIGNED, 4'h1, 4'h4, 1'b1},
    '{DMD_OP_MULTIPLY_UNSIGNED_BY_SIGNED, 4'h1, 4'h4, 1'b0}, '{DMD_OP_MULTIPLY_UNSIGNED_BY_UNSIGNED, 4'h1, 4'h4, 1'b1}, '{DMD_OP_MUL_SS, 4'h2, 4'h5, 1'b1},
    '{DMD_OP_MULTIPLY_SIGNED_BY_UNSIGNED, 4'h2, 4'h5, 1'b0}, '{DMD_OP_MULTIPLY_UNSIGNED_BY_SIGNED, 4'h3, 4'h2, 1'b1}, '{DMD_OP_MULTIPLY_UNSIGNED_BY_UNSIGNED, 4'h2, 4'h5, 1'b0},
    '{DMD_OP_NOP, 4'h3, 4'h3, 1'b1}};

  dmd_datapath dut (.*);
  dmd_mem_model xm (.core_clk_in, .rd_in(x_rd_out), .addr_in(x_addr_out), .rdata_out(x_rdata_in));
  dmd_mem_model ym (.core_clk_in, .rd_in(y_rd_out), .addr_in(y_addr_out), .rdata_out(y_rdata_in));

  always #25 core_clk_in = ~core_clk_in;

  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected value at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : give_verdict

  task automatic do_reset;
    reset_n_in = 1'b0;
    repeat (4) @(negedge core_clk_in);
    reset_n_in = 1'b1;
    foreach (rf[k]) rf[k] = 16'h0000;
    ea = '0;
    eb = '0;
    chk({busy_out, done_out, x_rd_out, wb_we_out, acc_a_out, acc_b_out}, '0);
  endtask : do_reset

  // issue one op from the fields already set, mirror it in rf/ea/eb
  task automatic go(input bit hold);
    logic signed [39:0] p;
    logic signed [33:0] m;
    logic [15:0]        a, b, xv, yv;
    a = rf[src_a_in];
    b = (use_imm_in && (op_in == DMD_OP_MULTIPLY_SIGNED_BY_UNSIGNED || op_in == DMD_OP_MULTIPLY_UNSIGNED_BY_UNSIGNED)) ? imm_in : rf[src_b_in];
    xv = xm.mem[rf[x_ptr_reg_in][6:1]];
    yv = ym.mem[rf[y_ptr_reg_in][6:1]];
    issue_in = 1'b1;
    @(negedge core_clk_in);
    if (op_in == DMD_OP_MSC) begin
      issue_in = hold;
      p = $signed(rf[src_a_in]) * $signed(rf[src_b_in]);
      if (acc_sel_in) eb = eb - p;
      else ea = ea - p;
      chk({busy_out, x_rd_out, y_rd_out}, {1'b1, x_en_in, y_en_in});
      chk(wb_we_out, wb_en_in);
      if (x_en_in) chk(x_addr_out, rf[x_ptr_reg_in]);
      if (y_en_in) chk(y_addr_out, rf[y_ptr_reg_in]);
      if (wb_en_in) chk({wb_addr_out, wb_data_out}, {accum_writeback_target_in, acc_sel_in ? ea[15:0] : eb[15:0]});
      @(negedge core_clk_in);
      issue_in = 1'b0;
      if (x_en_in) rf[x_dst_in] = xv;
      if (x_en_in) rf[x_ptr_reg_in] = rf[x_ptr_reg_in] + 16'(steps[x_incr_in]);
      if (y_en_in) rf[y_dst_in] = yv;
      if (y_en_in) rf[y_ptr_reg_in] = rf[y_ptr_reg_in] + 16'(steps[y_incr_in]);
    end else begin
      issue_in = 1'b0;
      m = $signed({(op_in == DMD_OP_MUL_SS || op_in == DMD_OP_MULTIPLY_SIGNED_BY_UNSIGNED) & a[15], a})
        * $signed({(op_in == DMD_OP_MUL_SS || op_in == DMD_OP_MULTIPLY_UNSIGNED_BY_SIGNED) & b[15], b});
      if (op_in != DMD_OP_NOP) rf[dst_in] = m[15:0];
      if (op_in != DMD_OP_NOP) rf[4'(dst_in + 4'h1)] = m[31:16];
    end
    chk(done_out, 1'b1);
    chk(acc_a_out, ea);
    chk(acc_b_out, eb);
    @(negedge core_clk_in);
  endtask : go

  // product words seen through a multiply-subtract by a register holding one
  task automatic obs(input logic [3:0] r, input logic s);
    op_in = DMD_OP_MSC;
    {src_a_in, src_b_in, acc_sel_in, wb_en_in, x_en_in, y_en_in} = {r, 4'h6, s, 1'b1, 2'b00};
    go(1'b0);
  endtask : obs

  always @(posedge core_clk_in) begin
    cyc++;
    if (cyc == 2000) begin
      err_count++;
      give_verdict();
    end
  end

  initial begin
    {acc_sel_in, use_imm_in, x_en_in, y_en_in, wb_en_in} = '0;
    {src_a_in, src_b_in, x_dst_in, y_dst_in} = '0;
    foreach (xm.mem[k]) xm.mem[k] = 16'(k * 5 + 1);
    foreach (ym.mem[k]) ym.mem[k] = 16'(k * 7 + 3);
    {xm.mem[0], xm.mem[1], xm.mem[2]} = {16'hfffd, 16'h8000, 16'h0007};
    {ym.mem[0], ym.mem[1], ym.mem[2], ym.mem[3]} = {16'hfff0, 16'h7fff, 16'h0001, 16'h0001};
    do_reset();
    op_in = DMD_OP_MSC;
    {src_a_in, src_b_in, x_en_in, y_en_in} = {4'h1, 4'h4, 2'b11};
    for (int i = 0; i < 3; i++) begin
      {acc_sel_in, wb_en_in, x_dst_in, y_dst_in} = {i[0], i[0], 4'(i + 1), 4'(i + 4)};
      go(i == 1);
    end
    {src_a_in, src_b_in, x_dst_in, y_dst_in, y_incr_in} = {4'h6, 4'ha, 4'ha, 4'h6, 3'h3};
    for (int i = 0; i < 8; i++) begin
      {x_incr_in, y_en_in} = {3'(i), i == 7};
      go(1'b0);
    end
    {x_en_in, y_en_in} = 2'b00;
    foreach (rows[i]) begin
      op_in = rows[i].op;
      {src_a_in, src_b_in, use_imm_in} = {rows[i].a, rows[i].b, rows[i].imm};
      go(1'b0);
      obs(4'h8, 1'b0);
      obs(4'h9, 1'b1);
    end
    do_reset();
    op_in = DMD_OP_MSC;
    {x_en_in, y_en_in} = 2'b11;
    go(1'b0);
    give_verdict();
  end
endmodule : testbench
